// ---- hdl/mtpa_engine.sv ----
/*
  Parameter access engine: takes one request frame as a byte stream, checks
  and executes it against the parameter store, and sends one response frame.
  Assumes frames are delimited by rx_last and that TCP framing lies outside.
*/
`timescale 1ns/1ns
`default_nettype none
module mtpa_engine
  import mtpa_pkg::*;
#(
  parameter int unsigned DATASETS = mtpa_pkg::DS_COUNT,
  parameter int unsigned PARAMS = mtpa_pkg::PAR_COUNT
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_last,
  output logic rx_ready,
  output logic tx_valid,
  output logic [7:0] tx_data,
  output logic tx_last,
  input wire logic tx_ready,
  output logic nv_store_valid,
  output mtpa_pkg::mtpa_store_t nv_store
);
  import mtpa_pkg::*;

  localparam int unsigned DEPTH = DATASETS * PARAMS;
  localparam int unsigned AW = $clog2(DEPTH);
  localparam int unsigned PW = (PARAMS > 1) ? $clog2(PARAMS) : 1;

  if (DATASETS != DS_COUNT || PARAMS != PAR_COUNT) begin : g_chk
    $error("mtpa_engine: dataset or parameter count differs from table");
  end

  typedef enum logic [2:0] {
    ST_INIT = 3'b000,
    ST_RECV = 3'b001,
    ST_LOOK = 3'b010,
    ST_READ = 3'b011,
    ST_SEND = 3'b100
  } mtpa_state_t;

  typedef enum logic [2:0] {
    OUT_EXC = 3'b000,
    OUT_RD16 = 3'b001,
    OUT_RD32 = 3'b010,
    OUT_ECHO = 3'b011,
    OUT_SUM = 3'b100
  } mtpa_out_t;

  mtpa_state_t state_r;
  mtpa_out_t out_r;
  mtpa_out_t out_nxt;
  logic [RX_MAX-1:0][7:0] rx_buf_r;
  logic [4:0] rx_cnt_r;
  logic [TX_MAX-1:0][7:0] tx_buf_r;
  logic [TX_MAX-1:0][7:0] resp_nxt;
  logic [7:0] tx_len_r;
  logic [7:0] resp_len;
  logic [7:0] tx_idx_r;
  logic [AW-1:0] init_addr_r;
  logic [PW-1:0] init_par_r;

  // Decoded request
  logic [7:0] fc;
  logic [15:0] arg;
  logic [3:0] ds;
  logic [11:0] pnum;
  logic [2:0] ds_store;
  logic ds_ok;
  logic [PARAMS-1:0] hit;
  logic [PW-1:0] hit_idx;
  logic known;
  mtpa_pdesc_t desc;
  logic [31:0] wr_val;
  logic in_range;
  logic mem_we;
  logic [AW-1:0] mem_addr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic build;

  assign fc = rx_buf_r[POS_FC];
  assign arg = {rx_buf_r[POS_ARG], rx_buf_r[POS_ARG+1]};
  assign ds = rx_buf_r[POS_ADDR][7:4];
  assign pnum = {rx_buf_r[POS_ADDR][3:0], rx_buf_r[POS_ADDR+1]};
  assign ds_ok = ds <= DS_LAST;
  assign ds_store = (ds >= DS_RAM_OFS) ? 3'(ds - DS_RAM_OFS) : ds[2:0];

  for (genvar i = 0; i < PARAMS; i++) begin : g_hit
    assign hit[i] = PAR_TABLE[i].num == pnum;
  end

  always_comb begin
    hit_idx = '0;
    for (int j = 0; j < PARAMS; j++) begin
      if (hit[j]) begin
        hit_idx = PW'(j);
      end
    end
  end

  assign desc = PAR_TABLE[hit_idx];
  assign known = (|hit) && ds_ok;
  // Code 6 takes the value from the argument word, code 16 from the data bytes
  assign wr_val = (fc == FC_WRITE_ONE) ? {16'h0000, arg} :
                  {16'h0000, rx_buf_r[POS_DATA], rx_buf_r[POS_DATA+1]};
  assign in_range = (wr_val >= desc.min_v) && (wr_val <= desc.max_v);

  always_comb begin
    out_nxt = OUT_EXC;
    case (fc)
      FC_READ: begin
        if (known && rx_cnt_r >= LEN_SHORT) begin
          if (!desc.wide && arg == REGS_16) begin
            out_nxt = OUT_RD16;
          end else if (desc.wide && arg == REGS_32) begin
            out_nxt = OUT_RD32;
          end
        end
      end
      FC_WRITE_ONE: begin
        if (known && rx_cnt_r >= LEN_SHORT && !desc.wide && in_range) begin
          out_nxt = OUT_ECHO;
        end
      end
      FC_WRITE_MANY: begin
        if (known && rx_cnt_r >= LEN_MANY16 && !desc.wide && arg == REGS_16 &&
            rx_buf_r[POS_BCNT] == BCNT_16 && in_range) begin
          out_nxt = OUT_SUM;
        end
      end
      default: begin
        out_nxt = OUT_EXC;
      end
    endcase
  end

  assign mem_we = (state_r == ST_INIT) ||
                  (state_r == ST_LOOK && (out_nxt == OUT_ECHO || out_nxt == OUT_SUM));
  assign mem_addr = (state_r == ST_INIT) ? init_addr_r :
                    AW'(ds_store * PARAMS + hit_idx);
  assign mem_wdata = (state_r == ST_INIT) ? PAR_TABLE[init_par_r].init_v : wr_val;

  mtpa_param_mem #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_mem (
    .clk(clk),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  assign build = (state_r == ST_LOOK && out_nxt != OUT_RD16 && out_nxt != OUT_RD32) ||
                 (state_r == ST_READ);

  // Response image
  always_comb begin
    mtpa_out_t sel;
    sel = (state_r == ST_READ) ? out_r : out_nxt;
    resp_nxt = '0;
    resp_len = TXL_EXC;
    for (int k = 0; k <= POS_UNIT; k++) begin
      resp_nxt[k] = rx_buf_r[k];
    end
    resp_nxt[POS_FC] = fc;
    case (sel)
      OUT_RD16: begin
        resp_len = TXL_RD16;
        resp_nxt[POS_ADDR] = BCNT_16;
        resp_nxt[POS_ADDR+1] = mem_rdata[15:8];
        resp_nxt[POS_ADDR+2] = mem_rdata[7:0];
      end
      OUT_RD32: begin
        resp_len = TXL_RD32;
        resp_nxt[POS_ADDR] = BCNT_32;
        resp_nxt[POS_ADDR+1] = mem_rdata[31:24];
        resp_nxt[POS_ADDR+2] = mem_rdata[23:16];
        resp_nxt[POS_ADDR+3] = mem_rdata[15:8];
        resp_nxt[POS_ADDR+4] = mem_rdata[7:0];
      end
      OUT_ECHO, OUT_SUM: begin
        resp_len = TXL_WR;
        for (int k = POS_ADDR; k < POS_BCNT; k++) begin
          resp_nxt[k] = rx_buf_r[k];
        end
      end
      default: begin
        resp_nxt[POS_FC] = fc | EXC_FLAG;
        resp_nxt[POS_ADDR] = EXC_SERVER_FAIL;
      end
    endcase
    resp_nxt[4] = 8'h00;
    resp_nxt[5] = resp_len - MBAP_HEAD;
  end

  // Sequencing
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_INIT;
    end else begin
      case (state_r)
        ST_INIT: begin
          if (init_addr_r == AW'(DEPTH - 1)) begin
            state_r <= ST_RECV;
          end
        end
        ST_RECV: begin
          if (rx_valid && rx_last) begin
            state_r <= ST_LOOK;
          end
        end
        ST_LOOK: begin
          state_r <= build ? ST_SEND : ST_READ;
        end
        ST_READ: begin
          state_r <= ST_SEND;
        end
        ST_SEND: begin
          if (tx_ready && tx_idx_r == tx_len_r - 8'd1) begin
            state_r <= ST_RECV;
          end
        end
        default: begin
          state_r <= ST_INIT;
        end
      endcase
    end
  end

  // Default fill of the store after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      init_addr_r <= '0;
      init_par_r <= '0;
    end else if (state_r == ST_INIT) begin
      init_addr_r <= init_addr_r + AW'(1);
      init_par_r <= (init_par_r == PW'(PARAMS - 1)) ? '0 : init_par_r + PW'(1);
    end
  end

  // Request capture; bytes beyond the longest frame are dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_cnt_r <= '0;
      rx_buf_r <= '0;
    end else if (state_r == ST_RECV && rx_valid) begin
      if (rx_cnt_r < 5'(RX_MAX)) begin
        rx_buf_r[rx_cnt_r] <= rx_data;
        rx_cnt_r <= rx_cnt_r + 5'd1;
      end
    end else if (state_r == ST_SEND) begin
      rx_cnt_r <= '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      out_r <= OUT_EXC;
    end else if (state_r == ST_LOOK) begin
      out_r <= out_nxt;
    end
  end

  // Response staging and drain
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_buf_r <= '0;
      tx_len_r <= TXL_EXC;
      tx_idx_r <= '0;
    end else if (build) begin
      tx_buf_r <= resp_nxt;
      tx_len_r <= resp_len;
      tx_idx_r <= '0;
    end else if (state_r == ST_SEND && tx_ready) begin
      tx_idx_r <= tx_idx_r + 8'd1;
    end
  end

  // Nonvolatile commit only for the stored datasets
  always_ff @(posedge clk) begin
    if (rst) begin
      nv_store_valid <= 1'b0;
      nv_store <= '0;
    end else begin
      nv_store_valid <= mem_we && state_r == ST_LOOK && ds < DS_RAM_OFS;
      if (mem_we && state_r == ST_LOOK) begin
        nv_store <= '{dataset: ds_store, num: pnum, value: wr_val};
      end
    end
  end

  assign rx_ready = state_r == ST_RECV;
  assign tx_valid = state_r == ST_SEND;
  assign tx_data = tx_buf_r[tx_idx_r[3:0]];
  assign tx_last = tx_valid && tx_idx_r == tx_len_r - 8'd1;

  sequence s_look;
    state_r == ST_LOOK;
  endsequence

  sequence s_built;
    ##1 state_r == ST_SEND;
  endsequence

  AST_READ16_REJECT: assert property (@(posedge clk) disable iff (rst)
    s_look and (fc == FC_READ && known && !desc.wide && arg == REGS_32)
    |-> s_built ##0 (tx_buf_r[POS_FC] == 8'h83 && tx_buf_r[POS_ADDR] == 8'h04))
    else $error("16-bit read with two registers not rejected");

  AST_READ32_REJECT: assert property (@(posedge clk) disable iff (rst)
    s_look and (fc == FC_READ && known && desc.wide && arg == REGS_16)
    |-> s_built ##0 (tx_buf_r[POS_FC] == 8'h83 && tx_len_r == TXL_EXC))
    else $error("32-bit read with one register not rejected");

  AST_EXC_CODE: assert property (@(posedge clk) disable iff (rst)
    tx_valid && tx_buf_r[POS_FC][7] && tx_idx_r == 8'(POS_ADDR)
    |-> tx_data == EXC_SERVER_FAIL && tx_last)
    else $error("exception code byte wrong");

  AST_RANGE_REJECT: assert property (@(posedge clk) disable iff (rst)
    s_look and (fc == FC_WRITE_ONE && known && !in_range)
    |-> !mem_we ##2 (tx_buf_r[POS_FC] == 8'h86))
    else $error("out-of-range write accepted");

  AST_ECHO: assert property (@(posedge clk) disable iff (rst)
    s_look and (out_nxt == OUT_ECHO)
    |=> tx_len_r == TXL_WR && tx_buf_r[POS_BCNT-1:0] == rx_buf_r[POS_BCNT-1:0])
    else $error("single write response is not a copy");

  AST_SUMMARY: assert property (@(posedge clk) disable iff (rst)
    s_look and (out_nxt == OUT_SUM)
    |=> tx_len_r == TXL_WR && {tx_buf_r[POS_ARG], tx_buf_r[POS_ARG+1]} == REGS_16)
    else $error("multiple write summary wrong");

  AST_RD16_DATA: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_READ && out_r == OUT_RD16
    |=> tx_buf_r[POS_ADDR] == BCNT_16 && tx_len_r == TXL_RD16 &&
        {tx_buf_r[POS_ADDR+1], tx_buf_r[POS_ADDR+2]} == $past(mem_rdata[15:0]))
    else $error("16-bit read data wrong");

  AST_RD32_DATA: assert property (@(posedge clk) disable iff (rst)
    state_r == ST_READ && out_r == OUT_RD32
    |=> tx_buf_r[POS_ADDR] == BCNT_32 && tx_len_r == TXL_RD32)
    else $error("32-bit read byte count wrong");

  AST_LENGTH: assert property (@(posedge clk) disable iff (rst)
    tx_valid |-> tx_buf_r[5] == tx_len_r - MBAP_HEAD &&
    tx_buf_r[POS_UNIT] == rx_buf_r[POS_UNIT] && tx_buf_r[3:0] == rx_buf_r[3:0])
    else $error("header fields not copied");

  AST_UNKNOWN: assert property (@(posedge clk) disable iff (rst)
    s_look and !known |-> out_nxt == OUT_EXC && !mem_we)
    else $error("unknown parameter not rejected");

  AST_RAM_ONLY: assert property (@(posedge clk) disable iff (rst)
    s_look and (mem_we && ds >= DS_RAM_OFS) |=> !nv_store_valid)
    else $error("RAM-only dataset reached nonvolatile store");
endmodule : mtpa_engine
`default_nettype wire

// ---- hdl/mtpa_param_mem.sv ----
/*
  Working copy of all parameter values, one word per dataset and parameter.
  Assumes the owner fills it after reset; read data come out of a register.
*/
`timescale 1ns/1ns
`default_nettype none
module mtpa_param_mem #(
  parameter int unsigned DEPTH = 20,
  parameter int unsigned AW = 5
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);
  logic [31:0] mem [DEPTH];

  if ((1 << AW) < DEPTH) begin : g_chk
    $error("mtpa_param_mem: address too narrow");
  end

  always_ff @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : mtpa_param_mem
`default_nettype wire

// ---- hdl/mtpa_pkg.sv ----
/*
  Shared constants, the parameter descriptor table and carrier types of the
  parameter access engine. Assumes one clock, one synchronous reset, and byte
  streams holding one whole request or response each.
*/
package mtpa_pkg;

  localparam logic [7:0] FC_READ = 8'h03;
  localparam logic [7:0] FC_WRITE_ONE = 8'h06;
  localparam logic [7:0] FC_WRITE_MANY = 8'h10;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_SERVER_FAIL = 8'h04;
  localparam logic [7:0] BCNT_16 = 8'h02;
  localparam logic [7:0] BCNT_32 = 8'h04;
  localparam logic [15:0] REGS_16 = 16'h0001;
  localparam logic [15:0] REGS_32 = 16'h0002;

  localparam int unsigned DS_COUNT = 5;
  localparam logic [3:0] DS_RAM_OFS = 4'h5;
  localparam logic [3:0] DS_LAST = 4'h9;

  // Byte positions inside a request or response
  localparam int unsigned POS_UNIT = 6;
  localparam int unsigned POS_FC = 7;
  localparam int unsigned POS_ADDR = 8;
  localparam int unsigned POS_ARG = 10;
  localparam int unsigned POS_BCNT = 12;
  localparam int unsigned POS_DATA = 13;
  localparam int unsigned RX_MAX = 17;
  localparam int unsigned TX_MAX = 13;
  localparam logic [4:0] LEN_SHORT = 5'd12;
  localparam logic [4:0] LEN_MANY16 = 5'd15;
  localparam logic [7:0] MBAP_HEAD = 8'd6;

  // Response lengths in bytes
  localparam logic [7:0] TXL_EXC = 8'd9;
  localparam logic [7:0] TXL_RD16 = 8'd11;
  localparam logic [7:0] TXL_RD32 = 8'd13;
  localparam logic [7:0] TXL_WR = 8'd12;

  typedef struct packed {
    logic [11:0] num;
    logic wide;
    logic [31:0] min_v;
    logic [31:0] max_v;
    logic [31:0] init_v;
  } mtpa_pdesc_t;

  localparam int unsigned PAR_COUNT = 4;
  localparam mtpa_pdesc_t PAR_TABLE [PAR_COUNT] = '{
    '{12'h174, 1'b0, 32'h0000_0001, 32'h0000_ffff, 32'h0000_056e},
    '{12'h178, 1'b0, 32'h0000_0001, 32'h0000_ffff, 32'h0000_000f},
    '{12'h1e1, 1'b1, 32'h0000_0000, 32'h0001_0000, 32'h0000_03e8},
    '{12'h1e2, 1'b1, 32'h0000_0000, 32'h0001_0000, 32'h0000_1162}
  };

  typedef struct packed {
    logic [2:0] dataset;
    logic [11:0] num;
    logic [31:0] value;
  } mtpa_store_t;

endpackage : mtpa_pkg

// ---- test/mtpa_engine_bench.sv ----
/*
  Self-checking bench of the parameter access engine: table of request and
  response frames, then a reset in mid-frame. Assumes the master model.
*/
`timescale 1ns/1ns
`default_nettype none
module mtpa_engine_bench;
  import mtpa_pkg::*;
  typedef struct packed {
    logic [87:0] rq;
    logic [7:0] rql;
    logic [55:0] rs;
    logic [7:0] rsl;
    logic nv;
  } mtpa_row_t;
  logic clk;
  logic rst;
  logic start;
  logic slow;
  logic [135:0] req;
  logic [7:0] req_len;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_last;
  logic rx_ready;
  logic tx_valid;
  logic [7:0] tx_data;
  logic tx_last;
  logic tx_ready;
  logic nv_store_valid;
  mtpa_store_t nv_store;
  mtpa_store_t nv_last;
  logic busy;
  logic [103:0] resp;
  logic [7:0] resp_len;
  logic [15:0] tid;
  mtpa_row_t rows [16];
  int nv_cnt;
  int err_total;
  int check_count;
  int i;

  mtpa_engine #(.DATASETS(DS_COUNT), .PARAMS(PAR_COUNT)) mtpa_engine_i (
    .clk(clk), .rst(rst), .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last),
    .tx_ready(tx_ready), .nv_store_valid(nv_store_valid), .nv_store(nv_store)
  );
  mtpa_master_model mtpa_master_model_i (
    .clk(clk), .rst(rst), .start(start), .slow(slow), .req(req), .req_len(req_len),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .busy(busy), .resp(resp), .resp_len(resp_len)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (nv_store_valid === 1'b1) begin
      nv_cnt = nv_cnt + 1;
      nv_last = nv_store;
    end
  end

  task automatic chk_frame(input string what, input logic [103:0] exp, input logic [103:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_frame

  task automatic chk_num(input string what, input logic [46:0] exp, input logic [46:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_num

  task finish_test;
    $display("Checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  task automatic launch(input logic [87:0] rq, input logic [7:0] rql);
    tid = tid + 16'h0001;
    req = {tid, 16'h0000, 8'h00, rql, rq << (8 * (11 - rql))};
    req_len = rql + 8'd6;
    nv_cnt = 0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
  endtask : launch

  task automatic wait_idle;
    int w;
    for (w = 0; w < 400 && busy; w++) @(negedge clk);
    if (busy) begin
      err_total++;
      $display("BAD idle wait expected 0 seen 1");
      finish_test();
    end
  endtask : wait_idle

  task automatic run(input mtpa_row_t r);
    launch(r.rq, r.rql);
    wait_idle();
    chk_frame("response", {tid, 16'h0000, 8'h00, r.rsl, r.rs << (8 * (7 - r.rsl))}, resp);
    chk_num("response length", 47'(r.rsl + 8'd6), 47'(resp_len));
    chk_num("nv pulses", 47'(r.nv), 47'(nv_cnt));
    if (r.nv) begin
      chk_num("nv store", {3'd4, 12'h178, 16'h0000, r.rq[15:0]}, nv_last);
    end
  endtask : run

  task automatic wait_ready;
    int w;
    for (w = 0; w < 40 && rx_ready !== 1'b1; w++) @(negedge clk);
    chk_num("ready after fill", 47'(1), 47'(rx_ready));
  endtask : wait_ready

  initial begin
    rst = 1'b1;
    start = 1'b0;
    slow = 1'b0;
    req = '0;
    req_len = 8'h00;
    tid = 16'h5a00;
    nv_cnt = 0;
    err_total = 0;
    check_count = 0;
    rows[0] = '{88'h010321740001, 8'd6, 56'h010302056e, 8'd5, 1'b0};
    rows[1] = '{88'h010301740002, 8'd6, 56'h018304, 8'd3, 1'b0};
    rows[2] = '{88'h03064178000f, 8'd6, 56'h03064178000f, 8'd6, 1'b1};
    rows[3] = '{88'h010341780001, 8'd6, 56'h010302000f, 8'd5, 1'b0};
    rows[4] = '{88'h030621780000, 8'd6, 56'h038604, 8'd3, 1'b0};
    rows[5] = '{88'h011041780001020010, 8'd9, 56'h011041780001, 8'd6, 1'b1};
    rows[6] = '{88'h031041780001020000, 8'd9, 56'h039004, 8'd3, 1'b0};
    rows[7] = '{88'h010311e10002, 8'd6, 56'h010304000003e8, 8'd7, 1'b0};
    rows[8] = '{88'h010301e10001, 8'd6, 56'h018304, 8'd3, 1'b0};
    rows[9] = '{88'h010691780022, 8'd6, 56'h010691780022, 8'd6, 1'b0};
    rows[10] = '{88'h010341780001, 8'd6, 56'h0103020022, 8'd5, 1'b0};
    rows[11] = '{88'h010326400001, 8'd6, 56'h018304, 8'd3, 1'b0};
    rows[12] = '{88'h0103a1740001, 8'd6, 56'h018304, 8'd3, 1'b0};
    rows[13] = '{88'h010391e20002, 8'd6, 56'h01030400001162, 8'd7, 1'b0};
    rows[14] = '{88'h010401740001, 8'd6, 56'h018404, 8'd3, 1'b0};
    rows[15] = '{88'h010601e10001, 8'd6, 56'h018604, 8'd3, 1'b0};
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    chk_num("ready during fill", 47'(0), 47'(rx_ready));
    wait_ready();
    // Odd rows stall the response stream
    for (i = 0; i < 16; i++) begin
      slow = i[0];
      run(rows[i]);
      $display("Row %0d done", i);
    end
    // Reset in mid-frame restores the defaults
    slow = 1'b0;
    launch(88'h010341780001, 8'd6);
    repeat (4) @(negedge clk);
    rst = 1'b1;
    @(negedge clk);
    chk_num("tx_valid in reset", 47'(0), 47'(tx_valid));
    chk_num("rx_ready in reset", 47'(0), 47'(rx_ready));
    chk_num("tx_last in reset", 47'(0), 47'(tx_last));
    chk_num("nv pulse in reset", 47'(0), 47'(nv_store_valid));
    rst = 1'b0;
    wait_idle();
    wait_ready();
    run('{88'h010341780001, 8'd6, 56'h010302000f, 8'd5, 1'b0});
    $display("Reset test done");
    finish_test();
  end
endmodule : mtpa_engine_bench
`default_nettype wire

// ---- test/mtpa_master_model.sv ----
/*
  Far-side model of the remote master: sends one request frame byte by byte
  and collects the response, promptly or with tx_ready stalls.
  Assumes the engine's clock and synchronous reset; rst aborts a transfer.
*/
`timescale 1ns/1ns
`default_nettype none
module mtpa_master_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic slow,
  input wire logic [135:0] req,
  input wire logic [7:0] req_len,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_last,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  output logic busy,
  output logic [103:0] resp,
  output logic [7:0] resp_len
);
  int i;
  int w;
  logic fin;
  logic late;
  logic rst_seen;

  // Reset seen at a clock edge, so the abort never races the bench's negedge
  always @(posedge clk) begin
    rst_seen <= rst;
  end

  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_last = 1'b0;
    tx_ready = 1'b0;
    busy = 1'b0;
    resp = '0;
    resp_len = 8'h00;
    forever begin
      @(posedge clk);
      if (start && !rst) begin
        busy = 1'b1;
        late = 1'b0;
        resp = '0;
        resp_len = 8'h00;
        @(negedge clk);
        // Whole frame, 16-bit fields high byte first
        for (i = 0; i < int'(req_len) && !rst_seen; i++) begin
          rx_valid = 1'b1;
          rx_data = req[135-8*i -: 8];
          rx_last = (i == int'(req_len) - 1);
          for (w = 0; w < 100 && !rx_ready && !rst_seen; w++) @(negedge clk);
          if (w >= 100) begin
            late = 1'b1;
          end
          @(posedge clk);
          @(negedge clk);
        end
        rx_valid = 1'b0;
        rx_last = 1'b0;
        // Released line shows no stale byte
        rx_data = ~rx_data;
        fin = 1'b0;
        for (w = 0; w < 200 && !fin && !rst_seen; w++) begin
          tx_ready = slow ? w[0] : 1'b1;
          if (tx_valid && tx_ready) begin
            resp[103-8*resp_len -: 8] = tx_data;
            resp_len = resp_len + 8'h01;
            fin = tx_last;
          end
          @(posedge clk);
          @(negedge clk);
        end
        tx_ready = 1'b0;
        // Missing end mark or a stuck request shows as an impossible length
        if (!fin || late) begin
          resp_len = 8'hff;
        end
        busy = 1'b0;
      end
    end
  end
endmodule : mtpa_master_model
`default_nettype wire
